// file: core/svw_core.sv
// How it works
// - comparison flag bit is read-only
// - enable and mode survive detector reset
// - enable bit starts the comparator
// - flag drives irq when on, interrupt mode
// - level register cleared only by presetn, not by detector or external reset
// - level register written only as byte
// - ten level codes, others prohibited
// - reset mode asserts reset when low
// - interrupt mode raises irq when low
// - irq may follow enable immediately
// - adequate supply gives no reset
// - external reset sets irq mask
// - flag is one only below threshold
// - detector reset sets cause flag
//
// Implementation choice: the APB register port.
`include "svw_map.svh"
`timescale 1ns/1ps
`default_nettype none
module svw_core
  import svw_pkg::*;
#(
  parameter int SETTLE_CYC = (`SVW_SETTLE_NS + `SVW_CLK_NS - 1) / `SVW_CLK_NS
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_resetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_below,
  output logic comparator_run,
  output logic [3:0] threshold_voltage,
  output logic undervolt_irq,
  output logic undervolt_reset_req,
  output logic settled
);
  svw_ctrl_type ctrl_ff;
  svw_state_type state_ff;
  logic [3:0] level_ff;
  logic cause_ff;
  logic mask_ff;
  logic pend_ff;
  logic rst_ff;
  logic [2:0] sync_ff;
  logic [2:0] ext_sync_ff;
  logic ext_low_ff;
  logic below_ff;
  logic [31:0] rdata_ff;
  logic [31:0] cnt_ff;
  logic wr;
  logic rd;
  logic hit;
  logic below;
  logic det_rst;
  logic [7:0] ctrl_rd;
  assign wr = psel && penable && pwrite && clk_en;
  assign rd = psel && penable && !pwrite && clk_en;
  assign pready = 1'b1;
  assign hit = (paddr == `SVW_CTRL_OFF) || (paddr == `SVW_LEVEL_OFF)
    || (paddr == `SVW_CAUSE_OFF) || (paddr == `SVW_STATUS_OFF);
  assign pslverr = psel && penable && !hit;
  // comparator input: three stages, agree on last two
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_ff <= 3'h0;
    else if (clk_en)
      sync_ff <= {sync_ff[1:0], cmp_below};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      below_ff <= 1'b0;
    else if (clk_en)
    begin
      if (!ctrl_ff.detector_on)
        below_ff <= 1'b0;
      else if (sync_ff[2] == sync_ff[1])
        below_ff <= sync_ff[2];
    end
  end
  assign below = below_ff && ctrl_ff.detector_on;
  assign det_rst = rst_ff;
  // control: detector reset does not clear it (reset is presetn only)
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= '0;
    else if (clk_en && wr && paddr == `SVW_CTRL_OFF && pstrb[0])
    begin
      ctrl_ff.detector_on <= pwdata[`SVW_BIT_ON];
      ctrl_ff.reset_mode_select <= pwdata[`SVW_BIT_MODE];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_ff <= `SVW_LEVEL_RST;
    else if (clk_en && wr && paddr == `SVW_LEVEL_OFF && pstrb[0])
      level_ff <= pwdata[3:0];
  end
  // reset request: mode and low supply
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_ff <= 1'b0;
    else if (clk_en)
      rst_ff <= ctrl_ff.detector_on && ctrl_ff.reset_mode_select && below;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_ff <= 1'b0;
    else if (clk_en)
    begin
      if (det_rst)
        cause_ff <= 1'b1;
      else if (wr && paddr == `SVW_CAUSE_OFF && pwdata[0])
        cause_ff <= 1'b0;
    end
  end
  // external reset pin: three stages, idle high after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_sync_ff <= 3'h7;
    else if (clk_en)
      ext_sync_ff <= {ext_sync_ff[1:0], ext_resetn};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_low_ff <= 1'b0;
    else if (clk_en)
    begin
      if (ext_sync_ff[2] == ext_sync_ff[1])
        ext_low_ff <= !ext_sync_ff[2];
    end
  end
  // mask set by external reset; pending sticky, set beats clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mask_ff <= 1'b1;
    else if (clk_en)
    begin
      if (ext_low_ff)
        mask_ff <= 1'b1;
      else if (wr && paddr == `SVW_STATUS_OFF)
        mask_ff <= pwdata[`SVW_BIT_MASK];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_ff <= 1'b0;
    else if (clk_en)
    begin
      if (undervolt_irq)
        pend_ff <= 1'b1;
      else if (wr && paddr == `SVW_STATUS_OFF && pwdata[`SVW_BIT_PEND])
        pend_ff <= 1'b0;
    end
  end
  assign undervolt_irq = ctrl_ff.detector_on && !ctrl_ff.reset_mode_select
    && below;
  assign undervolt_reset_req = rst_ff;
  assign comparator_run = ctrl_ff.detector_on;
  assign threshold_voltage = level_ff;
  // settle tracker for software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_ff <= SVW_OFF;
    else if (clk_en)
      case (state_ff)
        SVW_OFF:
          if (ctrl_ff.detector_on)
            state_ff <= SVW_SETTLE;
        SVW_SETTLE:
          if (!ctrl_ff.detector_on)
            state_ff <= SVW_OFF;
          else if (cnt_ff >= 32'(SETTLE_CYC - 1))
            state_ff <= SVW_READY;
        SVW_READY:
          if (!ctrl_ff.detector_on)
            state_ff <= SVW_OFF;
        default:
          state_ff <= SVW_OFF;
      endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= 32'h0;
    else if (clk_en)
      cnt_ff <= (state_ff == SVW_SETTLE) ? cnt_ff + 32'h1 : 32'h0;
  end
  assign settled = (state_ff == SVW_READY);
  assign ctrl_rd = {ctrl_ff.detector_on, 5'h00, ctrl_ff.reset_mode_select, below};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_ff <= 32'h0;
    else if (psel && !penable && clk_en)
    begin
      if (paddr == `SVW_CTRL_OFF)
        rdata_ff <= {24'h0, ctrl_rd};
      else if (paddr == `SVW_LEVEL_OFF)
        rdata_ff <= {28'h0, level_ff};
      else if (paddr == `SVW_CAUSE_OFF)
        rdata_ff <= {31'h0, cause_ff};
      else if (paddr == `SVW_STATUS_OFF)
        rdata_ff <= {29'h0, settled, pend_ff, mask_ff};
      else
        rdata_ff <= 32'h0;
    end
  end
  assign prdata = rdata_ff;
  a_irq_route: assert property (@(posedge pclk) disable iff (!presetn)
    undervolt_irq |-> ctrl_ff.detector_on && !ctrl_ff.reset_mode_select)
    else $error("irq outside interrupt mode");
  a_rst_cause: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && undervolt_reset_req) |=> cause_ff)
    else $error("cause flag not set");
  a_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_ff.detector_on |-> !undervolt_irq && !below)
    else $error("disabled detector active");
  a_mask_ext: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && ext_low_ff) |=> mask_ff)
    else $error("mask not set");

  // low supply seen in each mode
  sequence s_rst_mode_low;
    clk_en && ctrl_ff.detector_on && ctrl_ff.reset_mode_select && below;
  endsequence

  sequence s_irq_mode_low;
    ctrl_ff.detector_on && !ctrl_ff.reset_mode_select && below;
  endsequence

  a_reset_mode: assert property (@(posedge pclk) disable iff (!presetn)
    s_rst_mode_low |=> undervolt_reset_req)
    else $error("no reset request");

  a_irq_mode: assert property (@(posedge pclk) disable iff (!presetn)
    s_irq_mode_low |-> undervolt_irq)
    else $error("no irq in interrupt mode");

  a_no_rst_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !below) |=> !undervolt_reset_req)
    else $error("reset with adequate supply");

  a_pend_set: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && undervolt_irq) |=> pend_ff)
    else $error("pending not set");

  a_pend_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `SVW_STATUS_OFF && pwdata[`SVW_BIT_PEND] && !undervolt_irq)
    |=> !pend_ff)
    else $error("pending not cleared");

  a_cause_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (cause_ff && !(wr && paddr == `SVW_CAUSE_OFF && pwdata[0]))
    |=> cause_ff)
    else $error("cause flag lost");

  // register writes land
  a_ctrl_wr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `SVW_CTRL_OFF && pstrb[0])
    |=> ctrl_ff.detector_on == $past(pwdata[`SVW_BIT_ON]))
    else $error("enable write lost");

  a_lvl_wr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == `SVW_LEVEL_OFF && pstrb[0])
    |=> level_ff == $past(pwdata[3:0]))
    else $error("level write lost");

  // comparator path, read data hold, level hold
  a_below_off: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && !ctrl_ff.detector_on) |=> !below_ff)
    else $error("filter not forced off");

  a_sync_agree: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(below_ff) |-> $past(sync_ff[2]) && $past(sync_ff[1]))
    else $error("flag rose without agreement");

  a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |=> $stable(prdata))
    else $error("read data moved in access");

  a_level_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr && paddr == `SVW_LEVEL_OFF) |=> $stable(level_ff))
    else $error("level changed without write");
  a_flag_ro: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_rd[0] == below)
    else $error("flag not from comparator");
  a_run_on: assert property (@(posedge pclk) disable iff (!presetn)
    comparator_run == ctrl_ff.detector_on)
    else $error("comparator run mismatch");
endmodule // svw_core
`default_nettype wire

// file: core/svw_map.svh
`ifndef SVW_MAP_SVH
`define SVW_MAP_SVH
`define SVW_CTRL_IDX 16'hFFBE
`define SVW_LEVEL_IDX 16'hFFBF
`define SVW_CAUSE_IDX 16'hFFC8
`define SVW_STATUS_IDX 16'hFFC9
`define SVW_CTRL_OFF {`SVW_CTRL_IDX, 2'b00}
`define SVW_LEVEL_OFF {`SVW_LEVEL_IDX, 2'b00}
`define SVW_CAUSE_OFF {`SVW_CAUSE_IDX, 2'b00}
`define SVW_STATUS_OFF {`SVW_STATUS_IDX, 2'b00}
`define SVW_BIT_FLAG 0
`define SVW_BIT_MODE 1
`define SVW_BIT_LEGACY 4
`define SVW_BIT_ON 7
`define SVW_BIT_MASK 0
`define SVW_BIT_PEND 1
`define SVW_LEVEL_RST 4'h0
`define SVW_LEVEL_MAX 4'h9
`define SVW_SETTLE_NS 200000
`define SVW_CLK_NS 5
`endif

// file: core/svw_pkg.sv
package svw_pkg;
  typedef struct packed {
    logic detector_on;
    logic reset_mode_select;
  } svw_ctrl_type;
  typedef enum logic [2:0] {
    SVW_OFF = 3'b001,
    SVW_SETTLE = 3'b010,
    SVW_READY = 3'b100
  } svw_state_type;
endpackage

// file: tb/svw_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "svw_map.svh"
module svw_core_tb_top;
  localparam int SETTLE = 20;
  logic pclk = 0, presetn = 0, ext_resetn = 1, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0, cmp_below = 0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [3:0] pstrb = 4'h0, threshold_voltage;
  logic pready, pslverr, comparator_run, undervolt_irq, undervolt_reset_req, settled, ev;
  int failures = 0;
  int check_count = 0;
  svw_core #(.SETTLE_CYC(SETTLE)) dut (.pclk(pclk), .presetn(presetn),
    .ext_resetn(ext_resetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_below(cmp_below),
    .comparator_run(comparator_run), .threshold_voltage(threshold_voltage),
    .undervolt_irq(undervolt_irq), .undervolt_reset_req(undervolt_reset_req),
    .settled(settled));
  initial forever #2.5 pclk = ~pclk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // setup, access until pready, then release
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask
  task rd(input logic [17:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task t_reset;
    rd(`SVW_CTRL_OFF);
    chk("ctrl", 32'h0, rv & 32'h83);
    rd(`SVW_LEVEL_OFF);
    chk("level", 32'h0, rv);
    rd(`SVW_STATUS_OFF);
    chk("mask", 32'h1, rv & 32'h1);
  endtask
  task t_level;
    for (int c = 0; c < 10; c++)
    begin
      wr(`SVW_LEVEL_OFF, 32'(c));
      tick(1);
      chk("threshold", 32'(c), 32'(threshold_voltage));
    end
    apb(1'b1, `SVW_LEVEL_OFF, 32'h3, 4'h2);
    tick(1);
    chk("level_strb", 32'h9, 32'(threshold_voltage));
    wr(`SVW_CTRL_OFF, 32'h01);
    rd(`SVW_CTRL_OFF);
    chk("flag_ro", 32'h0, rv & 32'h83);
  endtask
  task t_irq;
    @(posedge pclk) cmp_below <= 1'b1;
    wr(`SVW_CTRL_OFF, 32'h80);
    tick(8);
    chk("run", 32'h1, 32'(comparator_run));
    chk("irq", 32'h1, 32'(undervolt_irq));
    chk("early", 32'h0, 32'(settled));
    chk("no_rst", 32'h0, 32'(undervolt_reset_req));
    rd(`SVW_CTRL_OFF);
    chk("flag", 32'h81, rv & 32'h83);
    rd(`SVW_STATUS_OFF);
    chk("pend", 32'h2, rv & 32'h2);
    wr(`SVW_CTRL_OFF, 32'h00);
    tick(2);
    chk("irq_off", 32'h0, 32'(undervolt_irq));
    wr(`SVW_STATUS_OFF, 32'h2);
    rd(`SVW_STATUS_OFF);
    chk("pend_clr", 32'h0, rv & 32'h3);
    rd(`SVW_CTRL_OFF);
    chk("flag_off", 32'h0, rv & 32'h83);
    @(posedge pclk) cmp_below <= 1'b0;
  endtask
  task t_rmode;
    wr(`SVW_CTRL_OFF, 32'h80);
    for (int k = 0; k < 3 * SETTLE && settled !== 1'b1; k++) @(posedge pclk);
    chk("settled", 32'h1, 32'(settled));
    wr(`SVW_CTRL_OFF, 32'h82);
    tick(8);
    chk("rst_ok", 32'h0, 32'(undervolt_reset_req));
    @(posedge pclk) cmp_below <= 1'b1;
    tick(8);
    chk("rst", 32'h1, 32'(undervolt_reset_req));
    chk("irq_rm", 32'h0, 32'(undervolt_irq));
    rd(`SVW_CAUSE_OFF);
    chk("cause", 32'h1, rv & 32'h1);
    wr(`SVW_CTRL_OFF, 32'h80);
    tick(2);
    chk("rst_off", 32'h0, 32'(undervolt_reset_req));
    wr(`SVW_CTRL_OFF, 32'h00);
    @(posedge pclk) cmp_below <= 1'b0;
    wr(`SVW_CAUSE_OFF, 32'h1);
    rd(`SVW_CAUSE_OFF);
    chk("cause_clr", 32'h0, rv & 32'h1);
  endtask
  task t_ext;
    wr(`SVW_STATUS_OFF, 32'h0);
    rd(`SVW_STATUS_OFF);
    chk("mask_clr", 32'h0, rv & 32'h1);
    @(posedge pclk) ext_resetn <= 1'b0;
    tick(6);
    @(posedge pclk) ext_resetn <= 1'b1;
    rd(`SVW_STATUS_OFF);
    chk("mask_ext", 32'h1, rv & 32'h1);
  endtask
  task t_bad;
    apb(1'b1, 18'h00100, 32'hFF, 4'hF);
    chk("werr", 32'h1, 32'(ev));
    rd(18'h00100);
    chk("rerr", 32'h1, 32'(ev));
    chk("rdat", 32'h0, rv);
  endtask
  task t_midrst;
    wr(`SVW_LEVEL_OFF, 32'h5);
    wr(`SVW_CTRL_OFF, 32'h82);
    @(posedge pclk) presetn <= 1'b0;
    tick(2);
    @(posedge pclk) presetn <= 1'b1;
    chk("run_rst", 32'h0, 32'(comparator_run));
    chk("lvl_rst", 32'h0, 32'(threshold_voltage));
    rd(`SVW_CTRL_OFF);
    chk("ctrl_rst", 32'h0, rv & 32'h83);
  endtask
  task results;
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_level();
    t_irq();
    t_rmode();
    t_ext();
    t_bad();
    t_midrst();
    results();
  end
  initial
  begin
    #20000;
    failures++;
    results();
  end
endmodule // svw_core_tb_top
`default_nettype wire
